// *** verilog/ecp_port_extended_control.sv ***
// Extended control, configuration and FIFO handshake of an ECP parallel port
// How it works
// RULE1 - word size register reads constant 10h
// RULE2 - resource config bit 7 reads zero
// RULE3 - bit 6 shows live interrupt line level
// RULE4 - bits 2:0 encode allocated DMA channel
// RULE5 - bits 5:3 encode allocated IRQ number
// RULE6 - control bits 7:5 hold mode, read/write
// RULE7 - fault enable low: pulse on nFault fall
// RULE8 - DMA enable allows DMA only if unmasked
// RULE9 - service mask blocks DMA and service interrupts
// RULE10 - hardware sets mask on service event
// RULE11 - mask set on TC or threshold reached
// RULE12 - bits 1,0 report FIFO full, empty
// RULE13 - mode 000: FIFO reset, open-collector controls
// RULE14 - mode 001: direction tri-states, pins readable
// RULE15 - mode 010: FIFO sent by compatibility handshake
// RULE16 - mode 011: ECP send or receive FIFO
// RULE17 - EPP gated, reserved idle, test FIFO only
// RULE18 - mode 111 maps config registers
// RULE19 - mode moves only via 000/001 rules
// RULE20 - modes 010/011 start automatic handshake
// RULE21 - leaving forward mode drops controls cleanly
// RULE22 - leaving reverse drops nAutoFd, discards bytes
// RULE23 - ack level tags data versus command
// RULE24 - run-length count repeats next byte
// RULE25 - clearing mask with valid condition interrupts
// RULE26 - interrupt is short low pulse, released
// RULE27 - FIFO is sixteen bytes deep
// RULE28 - reserved mode behaves as idle
`timescale 1ns/10ps
`default_nettype none
module ecp_port_extended_control
  import ecp_ext_pkg::*;
#(
  parameter int IRQ_PULSE_CYCLES = IRQ_PULSE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host bus pins and chip configuration
  input wire isa_in_t isaIn,
  input wire chip_cfg_t chipCfg,
  output logic [7:0] sdOut,
  output logic sdOe_n,
  output logic dreq,
  output logic irqOe_n,
  // Peripheral pins
  input wire per_in_t perIn,
  output logic [7:0] pdOut,
  output logic pdOe_n,
  output logic [3:0] ctrlOut,
  output logic [3:0] ctrlOe_n,
  output logic eppSelected
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    isa_in_t isa1;
    isa_in_t isa2;
    isa_in_t isa3;
    per_in_t per1;
    per_in_t per2;
    per_in_t per3;
    logic [7:0] dataLatch;
    logic [5:0] dcr;
    mode_t mode;
    logic faultDis;
    logic dma_allow;
    logic svc;
    logic [FIFO_DEPTH-1:0][8:0] mem;
    logic [FIFO_AW:0] wp;
    logic [FIFO_AW:0] rp;
    eng_t eng;
    logic [8:0] cur;
    logic [6:0] rleCnt;
    logic rlePend;
    logic [7:0] irqCnt;
    logic [7:0] sdOut;
    logic sdOe_n;
    logic dreq;
    logic irqOe_n;
    logic [7:0] pdOut;
    logic pdOe_n;
    logic [3:0] ctrlOut;
    logic [3:0] ctrlOe_n;
    logic epp;
  } state_t;

  state_t s_q;
  state_t s_d;

  // ----------------------------------------
  // Encoders for the resource register
  // ----------------------------------------
  function automatic logic [2:0] enc_irq(input logic [3:0] irq);
    case (irq)
      4'hf: enc_irq = 3'h6;
      4'he: enc_irq = 3'h5;
      4'hb: enc_irq = 3'h4;
      4'ha: enc_irq = 3'h3;
      4'h9: enc_irq = 3'h2;
      4'h7: enc_irq = 3'h1;
      4'h5: enc_irq = 3'h7;
      default: enc_irq = 3'h0;
    endcase
  endfunction

  function automatic logic [2:0] enc_dma(input logic [2:0] ch);
    case (ch)
      3'h3: enc_dma = 3'h3;
      3'h2: enc_dma = 3'h2;
      3'h1: enc_dma = 3'h1;
      default: enc_dma = 3'h0;
    endcase
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [FIFO_AW:0] cnt;
    logic [FIFO_AW:0] thr;
    logic full;
    logic empty;
    logic dir;
    logic fwd;
    logic rev;
    logic fifoOn;
    logic wrEv;
    logic rdEv;
    logic tcEv;
    logic push;
    logic pop;
    logic [8:0] pushVal;
    logic dmaOk;
    logic svcCond;
    logic pulse;
    logic [7:0] rdVal;
    s_d = s_q;
    cnt = s_q.wp - s_q.rp;
    thr = {1'b0, chipCfg.fifoThr} + 5'h01;
    // RULE27 sixteen-byte FIFO
    full = (cnt == DEPTH_W);
    empty = (cnt == 5'h00);
    dir = s_q.dcr[DCR_DIR];
    fwd = (s_q.mode == MODE_FIFO || s_q.mode == MODE_ECP) && !dir;
    rev = (s_q.mode == MODE_ECP) && dir;
    fifoOn = fwd || rev || s_q.mode == MODE_TEST;
    push = 1'b0;
    pop = 1'b0;
    pushVal = '0;
    pulse = 1'b0;
    rdVal = 8'h00;
    // RULE8 DMA gate
    dmaOk = s_q.dma_allow && !s_q.svc;

    // Two-flop synchronisers; edges are judged on the second and third stage
    s_d.isa1 = isaIn;
    s_d.isa2 = s_q.isa1;
    s_d.isa3 = s_q.isa2;
    s_d.per1 = perIn;
    s_d.per2 = s_q.per1;
    s_d.per3 = s_q.per2;
    wrEv = s_q.isa2.nIow && !s_q.isa3.nIow;
    rdEv = !s_q.isa2.nIor && s_q.isa3.nIor;
    tcEv = s_q.isa2.tc && !s_q.isa3.tc && !s_q.isa2.nDack;

    // Host register writes, taken on the trailing edge of the write strobe
    if (wrEv && !s_q.isa2.aen && s_q.isa2.nDack) begin
      if (s_q.isa2.addr == DATA_OFS) begin
        // RULE23 command bytes tagged low
        if (s_q.mode == MODE_ECP) begin
          if (!dir && !full) begin
            push = 1'b1;
            pushVal = {1'b0, s_q.isa2.data};
          end
        end else begin
          s_d.dataLatch = s_q.isa2.data;
        end
      end else if (s_q.isa2.addr == CTRL_OFS) begin
        s_d.dcr[DCR_WR_MSB:0] = s_q.isa2.data[DCR_WR_MSB:0];
        // RULE19 direction only in 001
        if (s_q.mode == MODE_BIDIR) begin
          s_d.dcr[DCR_DIR] = s_q.isa2.data[DCR_DIR];
        end
      end else if (s_q.isa2.addr == FIFO_OFS) begin
        // RULE17 test mode accepts bytes too
        if ((fwd || s_q.mode == MODE_TEST) && !full) begin
          push = 1'b1;
          pushVal = {1'b1, s_q.isa2.data};
        end
      end else if (s_q.isa2.addr == ECR_OFS) begin
        // RULE19 legal mode moves
        if (s_q.mode == MODE_COMPAT || s_q.mode == MODE_BIDIR ||
            s_q.isa2.data[7:6] == 2'b00) begin
          s_d.mode = mode_t'(s_q.isa2.data[7:5]);
        end
        // RULE7 re-enable with fault pending
        if (s_q.faultDis && !s_q.isa2.data[4] && !s_q.per2.nFault &&
            s_q.mode == MODE_ECP) begin
          pulse = 1'b1;
        end
        // RULE6 mode and control bits
        s_d.faultDis = s_q.isa2.data[4];
        s_d.dma_allow = s_q.isa2.data[3];
        // RULE9 setting the mask raises nothing
        s_d.svc = s_q.isa2.data[2];
      end
    end

    // DMA writes need no address, only the acknowledge
    if (wrEv && !s_q.isa2.nDack && dmaOk && (fwd || s_q.mode == MODE_TEST) && !full) begin
      push = 1'b1;
      pushVal = {1'b1, s_q.isa2.data};
    end

    // Host and DMA reads; the value is captured at the leading edge of the read strobe
    if (rdEv) begin
      if (!s_q.isa2.nDack) begin
        rdVal = s_q.mem[s_q.rp[FIFO_AW-1:0]][7:0];
        pop = dmaOk && !empty && (rev || (s_q.mode == MODE_TEST && dir));
      end else if (s_q.isa2.addr == DATA_OFS) begin
        // RULE14 pin levels in 001
        rdVal = (s_q.mode == MODE_BIDIR) ? s_q.per2.pd : s_q.dataLatch;
      end else if (s_q.isa2.addr == STAT_OFS) begin
        rdVal = {!s_q.per2.busy, s_q.per2.nAck, s_q.per2.pError, s_q.per2.select,
                 s_q.per2.nFault, 3'h0};
      end else if (s_q.isa2.addr == CTRL_OFS) begin
        rdVal = {2'h0, s_q.dcr};
      end else if (s_q.isa2.addr == FIFO_OFS) begin
        // RULE18 RULE1 config view in 111
        if (s_q.mode == MODE_CFG) begin
          rdVal = WORD_SIZE_VAL;
        end else begin
          // Empty FIFO returns the stale entry at the read pointer rather than stalling the bus
          rdVal = s_q.mem[s_q.rp[FIFO_AW-1:0]][7:0];
          pop = !empty && (rev || s_q.mode == MODE_TEST);
        end
      end else if (s_q.isa2.addr == RES_OFS) begin
        // RULE2 RULE3 RULE4 RULE5 resource readback
        if (s_q.mode == MODE_CFG) begin
          rdVal = {1'b0, s_q.isa2.irqLine, enc_irq(chipCfg.irqNum), enc_dma(chipCfg.dmaChan)};
        end
      end else if (s_q.isa2.addr == ECR_OFS) begin
        // RULE12 full and empty flags
        rdVal = {s_q.mode, s_q.faultDis, s_q.dma_allow, s_q.svc, full, empty};
      end
      s_d.sdOut = rdVal;
    end
    s_d.sdOe_n = s_q.isa2.nIor || (s_q.isa2.aen && s_q.isa2.nDack);

    // Handshake engine
    case (s_q.eng)
      ENG_IDLE: begin
        // RULE20 RULE15 RULE16 automatic transfer
        if (fwd && !empty) begin
          pop = 1'b1;
          s_d.cur = s_q.mem[s_q.rp[FIFO_AW-1:0]];
          s_d.eng = ENG_FSTB;
        end else if (rev && !full) begin
          // A pending count must still fetch the data byte it repeats
          s_d.eng = ENG_RWAIT;
        end
      end
      ENG_FSTB: begin
        if (s_q.per2.busy) begin
          s_d.eng = ENG_FREL;
        end
      end
      ENG_FREL: begin
        if (!s_q.per2.busy) begin
          s_d.eng = ENG_IDLE;
        end
      end
      ENG_RWAIT: begin
        if (!s_q.per2.nAck) begin
          s_d.cur = {s_q.per2.busy, s_q.per2.pd};
          s_d.eng = ENG_RREL;
          // RULE23 peripheral ack tags commands
          if (!s_q.per2.busy) begin
            if (!s_q.per2.pd[CMD_RLE_BIT]) begin
              s_d.rleCnt = s_q.per2.pd[6:0];
              s_d.rlePend = 1'b1;
            end
          end else begin
            push = 1'b1;
            pushVal = {1'b1, s_q.per2.pd};
          end
        end
      end
      ENG_RREL: begin
        if (s_q.per2.nAck) begin
          s_d.eng = (s_q.rlePend && s_q.cur[TAG_BIT]) ? ENG_RRPT : ENG_IDLE;
        end
      end
      ENG_RRPT: begin
        // RULE24 repeat count more copies
        if (s_q.rleCnt == 7'h00) begin
          s_d.rlePend = 1'b0;
          s_d.eng = ENG_IDLE;
        end else if (!full) begin
          push = 1'b1;
          pushVal = s_q.cur;
          s_d.rleCnt = s_q.rleCnt - 7'h01;
        end
      end
      default: s_d.eng = ENG_IDLE;
    endcase

    // RULE21 RULE22 abandon transfer on mode exit
    if (!fwd && !rev) begin
      s_d.eng = ENG_IDLE;
      s_d.rlePend = 1'b0;
    end

    // FIFO update
    if (push) begin
      s_d.mem[s_q.wp[FIFO_AW-1:0]] = pushVal;
      s_d.wp = s_q.wp + 5'h01;
    end
    if (pop) begin
      s_d.rp = s_q.rp + 5'h01;
    end
    // RULE13 RULE28 FIFO held outside FIFO modes
    if (!fifoOn) begin
      s_d.wp = '0;
      s_d.rp = '0;
    end

    // RULE11 service conditions
    svcCond = s_q.dma_allow ? tcEv :
              (dir ? (cnt >= thr) : ((DEPTH_W - cnt) >= thr));
    // RULE10 RULE25 hardware set, the cycle after a clear if the condition still holds
    if (fifoOn && !s_q.svc && svcCond) begin
      s_d.svc = 1'b1;
      pulse = 1'b1;
    end
    // RULE7 falling nFault while enabled
    if (s_q.mode == MODE_ECP && !s_q.faultDis && s_q.per3.nFault && !s_q.per2.nFault) begin
      pulse = 1'b1;
    end

    // RULE26 short low pulse, then release
    if (pulse) begin
      s_d.irqCnt = 8'(IRQ_PULSE_CYCLES);
    end else if (s_q.irqCnt != 8'h00) begin
      s_d.irqCnt = s_q.irqCnt - 8'h01;
    end
    s_d.irqOe_n = (s_d.irqCnt == 8'h00);

    // Requests stop as soon as the mask or a full/empty FIFO says so
    s_d.dreq = dmaOk && ((fwd || (s_q.mode == MODE_TEST && !dir)) ? !s_d.wp[FIFO_AW] ^
               (s_d.wp[FIFO_AW-1:0] != s_d.rp[FIFO_AW-1:0]) || (s_d.wp == s_d.rp) :
               (rev || s_q.mode == MODE_TEST) && (s_d.wp != s_d.rp));
    if (dmaOk && (fwd || (s_q.mode == MODE_TEST && !dir))) begin
      s_d.dreq = ((s_d.wp - s_d.rp) != DEPTH_W);
    end

    // Peripheral pins: engine byte in forward 010/011 transfers, data register in every other mode
    s_d.pdOut = fwd ? s_q.cur[7:0] : s_q.dataLatch;
    // RULE13 RULE14 direction ignored in 000 and 010
    s_d.pdOe_n = dir && s_q.mode != MODE_COMPAT && s_q.mode != MODE_FIFO;
    s_d.ctrlOut = {!s_q.dcr[3], s_q.dcr[2], !s_q.dcr[1], !s_q.dcr[0]};
    if (s_q.eng == ENG_FSTB || s_q.eng == ENG_FREL) begin
      // Strobe low until the peripheral answers busy; ECP puts the tag on nAutoFd
      s_d.ctrlOut[0] = (s_q.eng != ENG_FSTB);
      if (s_q.mode == MODE_ECP) begin
        s_d.ctrlOut[1] = s_q.cur[TAG_BIT];
      end
    end else if (rev) begin
      s_d.ctrlOut[1] = (s_q.eng != ENG_RWAIT);
    end
    // RULE13 open-collector in 000, push-pull elsewhere
    s_d.ctrlOe_n = (s_d.mode == MODE_COMPAT) ? s_d.ctrlOut : 4'h0;
    // RULE17 EPP only with option enabled
    s_d.epp = (s_q.mode == MODE_EPP) && chipCfg.eppEnable;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.isa1 <= '1;
      s_q.isa2 <= '1;
      s_q.isa3 <= '1;
      s_q.per1 <= '1;
      s_q.per2 <= '1;
      s_q.per3 <= '1;
      s_q.mode <= MODE_COMPAT;
      s_q.faultDis <= RST_FAULT_DIS;
      s_q.dma_allow <= RST_DMA_EN;
      s_q.svc <= RST_SVC;
      s_q.eng <= ENG_IDLE;
      s_q.sdOe_n <= 1'b1;
      s_q.irqOe_n <= 1'b1;
      s_q.ctrlOut <= CTRL_RST;
      s_q.ctrlOe_n <= CTRL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign sdOut = s_q.sdOut;
  assign sdOe_n = s_q.sdOe_n;
  assign dreq = s_q.dreq;
  assign irqOe_n = s_q.irqOe_n;
  assign pdOut = s_q.pdOut;
  assign pdOe_n = s_q.pdOe_n;
  assign ctrlOut = s_q.ctrlOut;
  assign ctrlOe_n = s_q.ctrlOe_n;
  assign eppSelected = s_q.epp;

endmodule // ecp_port_extended_control
`default_nettype wire

// *** verilog/ecp_ext_pkg.sv ***
// Shared constants, types and register layout of the extended-control block
`default_nettype none
package ecp_ext_pkg;
  // ----------------------------------------
  // Register offsets from the port base
  // ----------------------------------------
  localparam logic [10:0] DATA_OFS = 11'h000;
  localparam logic [10:0] STAT_OFS = 11'h001;
  localparam logic [10:0] CTRL_OFS = 11'h002;
  localparam logic [10:0] FIFO_OFS = 11'h400;
  localparam logic [10:0] RES_OFS = 11'h401;
  localparam logic [10:0] ECR_OFS = 11'h402;
  localparam logic [7:0] WORD_SIZE_VAL = 8'h10;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int DCR_DIR = 5;
  localparam int DCR_WR_MSB = 4;
  localparam int CMD_RLE_BIT = 7;
  localparam int TAG_BIT = 8;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic RST_FAULT_DIS = 1'b1;
  localparam logic RST_DMA_EN = 1'b0;
  localparam logic RST_SVC = 1'b1;
  localparam logic [3:0] CTRL_RST = 4'hb;
  // ----------------------------------------
  // FIFO and timing
  // ----------------------------------------
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
  localparam logic [FIFO_AW:0] DEPTH_W = 5'h10;
  localparam int CLK_PERIOD_NS = 4;
  localparam int IRQ_PULSE_NS = 100;
  localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ----------------------------------------
  // Modes and handshake engine states
  // ----------------------------------------
  typedef enum logic [2:0] {
    MODE_COMPAT = 3'h0, MODE_BIDIR = 3'h1, MODE_FIFO = 3'h2, MODE_ECP = 3'h3,
    MODE_EPP = 3'h4, MODE_RSVD = 3'h5, MODE_TEST = 3'h6, MODE_CFG = 3'h7
  } mode_t;
  typedef enum logic [5:0] {
    ENG_IDLE = 6'h01, ENG_FSTB = 6'h02, ENG_FREL = 6'h04,
    ENG_RWAIT = 6'h08, ENG_RREL = 6'h10, ENG_RRPT = 6'h20
  } eng_t;
  // ----------------------------------------
  // Pin groups
  // ----------------------------------------
  typedef struct packed {
    logic nIor;
    logic nIow;
    logic aen;
    logic nDack;
    logic tc;
    logic irqLine;
    logic [10:0] addr;
    logic [7:0] data;
  } isa_in_t;
  typedef struct packed {
    logic nFault;
    logic busy;
    logic nAck;
    logic pError;
    logic select;
    logic [7:0] pd;
  } per_in_t;
  typedef struct packed {
    logic [2:0] dmaChan;
    logic [3:0] irqNum;
    logic eppEnable;
    logic [3:0] fifoThr;
  } chip_cfg_t;
endpackage
`default_nettype wire

// *** verification/ecp_periph_model.sv ***
// Behavioural parallel-port peripheral facing the extended-control block
`timescale 1ns/10ps
`default_nettype none
module ecp_periph_model
  import ecp_ext_pkg::*;
(
  // Host-driven pins
  input wire logic [7:0] pdOut,
  input wire logic pdOe_n,
  input wire logic [3:0] ctrlOut,
  input wire logic [3:0] ctrlOe_n,
  // Bench controls
  input wire logic slow,
  input wire logic faultN,
  // Pins seen by the host and capture report
  output var per_in_t perIn,
  output logic fwdValid,
  output logic [8:0] fwdWord
);
  logic [8:0] revQ[$];
  logic [8:0] cur;
  // Idle levels; status lines never float in this model
  initial begin
    perIn = '{nFault: 1'b1, busy: 1'b0, nAck: 1'b1, pError: 1'b0, select: 1'b1, pd: 8'h00};
    fwdValid = 1'b0;
    fwdWord = 9'h000;
  end
  always @(faultN) begin
    perIn.nFault = faultN;
  end
  always @(negedge ctrlOut[0]) begin
    if (!pdOe_n && ctrlOe_n == 4'h0) begin
      #(slow ? 40 : 4);
      fwdWord = {ctrlOut[1], pdOut};
      perIn.busy = 1'b1;
      fwdValid = 1'b1;
      #4;
      fwdValid = 1'b0;
      wait (ctrlOut[0]);
      #(slow ? 40 : 4);
      perIn.busy = 1'b0;
    end
  end
  always begin
    while (!(revQ.size() > 0 && pdOe_n === 1'b1 && ctrlOut[1] === 1'b0 && ctrlOe_n === 4'h0)) begin
      #4;
    end
    cur = revQ.pop_front();
    #(slow ? 40 : 8);
    perIn.pd = cur[7:0];
    perIn.busy = cur[8];
    #8;
    perIn.nAck = 1'b0;
    wait (ctrlOut[1]);
    perIn.nAck = 1'b1;
    #8;
    // Released bus shows a changed value, never the old byte
    perIn.pd = ~cur[7:0];
  end
endmodule // ecp_periph_model
`default_nettype wire

// *** verification/ecp_port_extended_control_assertions.sv ***
// Port-level checker for the extended-control block
`timescale 1ns/10ps
`default_nettype none
module ecp_ext_checker
  import ecp_ext_pkg::*;
#(
  parameter int IRQ_PULSE_CYCLES = IRQ_PULSE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host side
  input wire isa_in_t isaIn,
  input wire chip_cfg_t chipCfg,
  input wire logic [7:0] sdOut,
  input wire logic sdOe_n,
  input wire logic dreq,
  input wire logic irqOe_n,
  // Peripheral side
  input wire per_in_t perIn,
  input wire logic [7:0] pdOut,
  input wire logic pdOe_n,
  input wire logic [3:0] ctrlOut,
  input wire logic [3:0] ctrlOe_n,
  input wire logic eppSelected
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] irqCnt_q;
  // Length of the current low phase of the interrupt pin
  always_ff @(posedge clk) begin
    if (!rst_n || irqOe_n) begin
      irqCnt_q <= 8'h00;
    end else begin
      irqCnt_q <= irqCnt_q + 8'h01;
    end
  end
  sequence s_strobeLow2;
    ctrlOe_n == 4'h0 && !ctrlOut[0] ##1 !ctrlOut[0];
  endsequence
  property p_rstVals;
    $rose(rst_n) |-> irqOe_n && sdOe_n && !dreq && ctrlOut == CTRL_RST && !eppSelected;
  endproperty
  property p_ocCtrl;
    ctrlOe_n == 4'h0 || ctrlOe_n == ctrlOut;
  endproperty
  property p_irqMax;
    !irqOe_n |-> irqCnt_q < IRQ_PULSE_CYCLES;
  endproperty
  property p_irqLen;
    $rose(irqOe_n) |-> irqCnt_q == IRQ_PULSE_CYCLES;
  endproperty
  property p_sdOe;
    $fell(isaIn.nIor) && !isaIn.aen |-> ##[2:4] !sdOe_n;
  endproperty
  property p_epp;
    eppSelected |-> $past(chipCfg.eppEnable);
  endproperty
  property p_fwdStable;
    s_strobeLow2 |-> $stable(pdOut);
  endproperty
  property p_fwdDrive;
    ctrlOe_n == 4'h0 && !ctrlOut[0] |-> !pdOe_n;
  endproperty
  property p_strobeBusy;
    ctrlOe_n == 4'h0 && $rose(ctrlOut[0]) |-> $past(perIn.busy, 2);
  endproperty
  a_rstVals: assert property (p_rstVals) else $error("outputs not idle after reset");
  a_ocCtrl: assert property (p_ocCtrl) else $error("control enable not open or push");
  a_irqMax: assert property (p_irqMax) else $error("interrupt pulse too long");
  a_irqLen: assert property (p_irqLen) else $error("interrupt pulse length wrong");
  a_sdOe: assert property (p_sdOe) else $error("read data not driven");
  a_epp: assert property (p_epp) else $error("EPP selected while option off");
  a_fwdStable: assert property (p_fwdStable) else $error("data moved under strobe");
  a_fwdDrive: assert property (p_fwdDrive) else $error("strobe without data drive");
  a_strobeBusy: assert property (p_strobeBusy) else $error("strobe released early");
endmodule // ecp_ext_checker
bind ecp_port_extended_control ecp_ext_checker #(.IRQ_PULSE_CYCLES(IRQ_PULSE_CYCLES)) checker_i (
  .clk(clk), .rst_n(rst_n), .isaIn(isaIn), .chipCfg(chipCfg), .sdOut(sdOut),
  .sdOe_n(sdOe_n), .dreq(dreq), .irqOe_n(irqOe_n), .perIn(perIn), .pdOut(pdOut),
  .pdOe_n(pdOe_n), .ctrlOut(ctrlOut), .ctrlOe_n(ctrlOe_n), .eppSelected(eppSelected));
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench for the extended-control block
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import ecp_ext_pkg::*;
;
  localparam int PULSE = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  isa_in_t isaIn;
  chip_cfg_t chipCfg;
  per_in_t perIn;
  logic [7:0] sdOut, pdOut, b;
  logic sdOe_n, dreq, irqOe_n, pdOe_n, eppSelected, slow, faultN, fwdValid;
  logic sdOePrev = 1'b1;
  logic irqPrev = 1'b1;
  logic [3:0] ctrlOut, ctrlOe_n;
  logic [8:0] fwdWord;
  logic [7:0] rdQ[$];
  logic [7:0] fifoQ[$];
  logic [8:0] fwdQ[$];
  int fails = 0;
  int n_checks = 0;
  int irqSeen = 0;
  int irqExp = 0;
  integer seed = 32'hcb5e;
  always #2 clk = ~clk;
  ecp_port_extended_control #(.IRQ_PULSE_CYCLES(PULSE)) ecp_port_extended_control_i (
    .clk(clk), .rst_n(rst_n), .isaIn(isaIn), .chipCfg(chipCfg), .sdOut(sdOut),
    .sdOe_n(sdOe_n), .dreq(dreq), .irqOe_n(irqOe_n), .perIn(perIn), .pdOut(pdOut),
    .pdOe_n(pdOe_n), .ctrlOut(ctrlOut), .ctrlOe_n(ctrlOe_n), .eppSelected(eppSelected));
  ecp_periph_model ecp_periph_model_i (
    .pdOut(pdOut), .pdOe_n(pdOe_n), .ctrlOut(ctrlOut), .ctrlOe_n(ctrlOe_n), .slow(slow),
    .faultN(faultN), .perIn(perIn), .fwdValid(fwdValid), .fwdWord(fwdWord));
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [8:0] exp, input logic [8:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: expected %h, got %h", $time, exp, got);
    end
  endtask
  // ----
  // Watchers: read data, interrupts, forward bytes
  // ----
  always @(negedge clk) begin
    if (!sdOe_n && sdOePrev && rdQ.size() > 0) begin
      cmp({1'b0, rdQ.pop_front()}, {1'b0, sdOut});
    end
    if (!irqOe_n && irqPrev) begin
      irqSeen++;
    end
    sdOePrev = sdOe_n;
    irqPrev = irqOe_n;
  end
  always @(posedge fwdValid) begin
    cmp(fwdQ.pop_front(), fwdWord);
  end
  // Host strobe held well past the two-flop input sync on both sides
  task automatic busOp(input logic wr, input logic [10:0] a, input logic [7:0] d);
    @(negedge clk);
    isaIn.addr = a;
    isaIn.data = d;
    isaIn.nIow = !wr;
    isaIn.nIor = wr;
    repeat (5) @(negedge clk);
    isaIn.nIow = 1'b1;
    isaIn.nIor = 1'b1;
    repeat (5) @(negedge clk);
  endtask
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    busOp(1'b1, a, d);
  endtask
  task automatic rd(input logic [10:0] a, input logic [7:0] e);
    rdQ.push_back(e);
    busOp(1'b0, a, 8'h00);
  endtask
  task automatic irqChk;
    repeat (30) @(negedge clk);
    cmp(9'(irqExp), 9'(irqSeen));
  endtask
  task automatic drain;
    for (int i = 0; i < 4000; i++) begin
      if (fwdQ.size() == 0 && ecp_periph_model_i.revQ.size() == 0) break;
      @(negedge clk);
    end
    if (fwdQ.size() != 0 || ecp_periph_model_i.revQ.size() != 0) begin
      fails++;
      print_verdict();
    end
    repeat (40) @(negedge clk);
  endtask
  task automatic endTest(input string n);
    $display("Test %0s done, checks %0d", n, n_checks);
  endtask
  function automatic logic [5:0] resEnc(input logic [3:0] irq, input logic [2:0] dma);
    logic [2:0] ie;
    case (irq)
      4'hf: ie = 3'h6;
      4'he: ie = 3'h5;
      4'hb: ie = 3'h4;
      4'ha: ie = 3'h3;
      4'h9: ie = 3'h2;
      4'h7: ie = 3'h1;
      4'h5: ie = 3'h7;
      default: ie = 3'h0;
    endcase
    return {ie, (dma == 3'h1 || dma == 3'h2 || dma == 3'h3) ? dma : 3'h0};
  endfunction
  // ----
  // Main sequence
  // ----
  initial begin
    isaIn = '{nIor: 1'b1, nIow: 1'b1, aen: 1'b0, nDack: 1'b1, tc: 1'b0, irqLine: 1'b0,
      addr: 11'h000, data: 8'h00};
    chipCfg = '{dmaChan: 3'h0, irqNum: 4'h0, eppEnable: 1'b1, fifoThr: 4'h3};
    slow = 1'b0;
    faultN = 1'b1;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    rd(ECR_OFS, 8'h15);
    rd(11'h003, 8'h00);
    endTest("reset");
    wr(ECR_OFS, 8'hf4);
    for (int i = 0; i < 16; i++) begin
      chipCfg.irqNum = i[3:0];
      chipCfg.dmaChan = i[2:0];
      b = 8'($random(seed));
      isaIn.irqLine = b[0];
      rd(RES_OFS, {1'b0, b[0], resEnc(i[3:0], i[2:0])});
    end
    wr(FIFO_OFS, 8'h55);
    rd(FIFO_OFS, WORD_SIZE_VAL);
    wr(ECR_OFS, 8'h54);
    rd(ECR_OFS, 8'hf5);
    wr(ECR_OFS, 8'h34);
    rd(ECR_OFS, 8'h35);
    rd(RES_OFS, 8'h00);
    endTest("config");
    // Test FIFO: fill past full, threshold edge, unmask with condition valid
    wr(ECR_OFS, 8'hd4);
    for (int i = 0; i < 16; i++) begin
      b = 8'($random(seed));
      fifoQ.push_back(b);
      wr(FIFO_OFS, b);
    end
    wr(FIFO_OFS, 8'hee);
    rd(ECR_OFS, 8'hd6);
    repeat (3) rd(FIFO_OFS, fifoQ.pop_front());
    wr(ECR_OFS, 8'hd0);
    irqChk();
    rd(FIFO_OFS, fifoQ.pop_front());
    irqExp++;
    irqChk();
    rd(ECR_OFS, 8'hd4);
    wr(ECR_OFS, 8'hd0);
    irqExp++;
    irqChk();
    wr(ECR_OFS, 8'hd4);
    irqChk();
    while (fifoQ.size() > 0) rd(FIFO_OFS, fifoQ.pop_front());
    rd(ECR_OFS, 8'hd5);
    endTest("test fifo");
    wr(ECR_OFS, 8'hd8);
    cmp(9'(dreq), 9'h001);
    isaIn.nDack = 1'b0;
    isaIn.tc = 1'b1;
    repeat (6) @(negedge clk);
    isaIn.tc = 1'b0;
    isaIn.nDack = 1'b1;
    irqExp++;
    irqChk();
    cmp(9'(dreq), 9'h000);
    rd(ECR_OFS, 8'hdd);
    endTest("dma");
    wr(ECR_OFS, 8'h34);
    wr(ECR_OFS, 8'hb4);
    wr(FIFO_OFS, 8'h77);
    rd(ECR_OFS, 8'hb5);
    wr(ECR_OFS, 8'h34);
    wr(ECR_OFS, 8'h94);
    cmp(9'(eppSelected), 9'h001);
    wr(ECR_OFS, 8'h34);
    cmp(9'(eppSelected), 9'h000);
    endTest("modes");
    wr(ECR_OFS, 8'h74);
    for (int i = 0; i < 8; i++) begin
      slow = i[1];
      b = 8'($random(seed));
      fwdQ.push_back({i[0], b});
      wr(i[0] ? FIFO_OFS : DATA_OFS, b);
    end
    drain();
    wr(ECR_OFS, 8'h64);
    faultN = 1'b0;
    irqExp++;
    irqChk();
    wr(ECR_OFS, 8'h74);
    wr(ECR_OFS, 8'h64);
    irqExp++;
    irqChk();
    faultN = 1'b1;
    wr(ECR_OFS, 8'h34);
    wr(ECR_OFS, 8'h54);
    for (int i = 0; i < 4; i++) begin
      b = 8'($random(seed));
      fwdQ.push_back({1'b1, b});
      wr(FIFO_OFS, b);
    end
    drain();
    endTest("forward");
    wr(ECR_OFS, 8'h34);
    wr(CTRL_OFS, 8'h20);
    ecp_periph_model_i.revQ.push_back(9'h002);
    ecp_periph_model_i.revQ.push_back(9'h1a5);
    ecp_periph_model_i.revQ.push_back(9'h000);
    ecp_periph_model_i.revQ.push_back(9'h13c);
    wr(ECR_OFS, 8'h74);
    drain();
    repeat (3) rd(FIFO_OFS, 8'ha5);
    rd(FIFO_OFS, 8'h3c);
    rd(ECR_OFS, 8'h75);
    ecp_periph_model_i.revQ.push_back(9'h199);
    drain();
    wr(ECR_OFS, 8'h34);
    cmp(9'(ctrlOut[1]), 9'h001);
    wr(ECR_OFS, 8'h74);
    rd(ECR_OFS, 8'h75);
    wr(ECR_OFS, 8'h34);
    endTest("reverse");
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
